// ---- logic/sequencer_pkg.sv ----
// Constants and encodings shared by the event/action sequencer.
package sequencer_pkg;
    localparam int MAX_PAIRS = 20;
    localparam int IDX_W = 5;
    localparam int CODE_W = 6;
    localparam int EXT_W = 4;
    localparam int TIMER_W = 16;
    localparam logic [IDX_W-1:0] FIRST_SLOT = 5'h00;
    localparam logic [IDX_W-1:0] MAX_COUNT = 5'h14;
    // Event selection codes.
    localparam logic [CODE_W-1:0] EV_FALSE = 6'h00;
    localparam logic [CODE_W-1:0] EV_TRUE = 6'h01;
    localparam logic [CODE_W-1:0] EV_ON_REF = 6'h04;
    localparam logic [CODE_W-1:0] EV_TIMEOUT0 = 6'h1E;
    localparam logic [CODE_W-1:0] EV_EXT_BASE = 6'h20;
    // Action selection codes.
    localparam logic [CODE_W-1:0] ACT_NONE = 6'h01;
    localparam logic [CODE_W-1:0] ACT_PRESET0 = 6'h0A;
    localparam logic [CODE_W-1:0] ACT_PRESET1 = 6'h0B;
    localparam logic [CODE_W-1:0] ACT_TIMER0 = 6'h1D;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
    localparam logic [IDX_W-1:0] IDX_ONE = 5'h01;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } seq_state_t;
endpackage : sequencer_pkg

// ---- logic/event_action_sequencer.sv ----
// Event/action sequencer that steps through programmed pairs on a scan tick.
// How it works
// [RULE1] Action n is issued exactly when event n is found true.
// [RULE2] After action n fires the pointer moves on to event n+1.
// [RULE3] Only the slot at the pointer is tested on each scan.
// [RULE4] A false event means no action and a retry of the same slot next scan.
// [RULE5] Starting sets the pointer to the first slot.
// [RULE6] The programmed pair count runs from zero to twenty.
// [RULE7] After the last programmed pair fires, the pointer wraps to the first.
// [RULE8] Event and action codes live in two arrays indexed by pair number.
// [RULE9] Events come from external inputs or internal drive status.
// [RULE10] The sequencer runs only while its mode setting is on.
// [RULE11] Event codes 0 false, 1 true, 4 on reference, 30 timer zero expired are decoded.
// [RULE12] Action codes 1 none, 10 preset zero, 11 preset one, 29 start timer zero are decoded.
// [RULE13] One evaluation per scan tick, and no actions when the pair count is zero.
`timescale 1ns/1ps
module event_action_sequencer #(
    parameter int PAIRS = sequencer_pkg::MAX_PAIRS,
    parameter logic [sequencer_pkg::TIMER_W-1:0] TIMER0_LOAD = 16'h0064
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic mode_on,
    input wire logic scan_tick,
    input wire logic [sequencer_pkg::IDX_W-1:0] pair_count,
    input wire logic prog_we,
    input wire logic [sequencer_pkg::IDX_W-1:0] prog_idx,
    input wire logic [sequencer_pkg::CODE_W-1:0] prog_event,
    input wire logic [sequencer_pkg::CODE_W-1:0] prog_action,
    input wire logic on_reference,
    input wire logic [sequencer_pkg::EXT_W-1:0] ext_in,
    output logic [sequencer_pkg::IDX_W-1:0] current_slot,
    output logic action_fire,
    output logic [sequencer_pkg::CODE_W-1:0] action_code,
    output logic preset_sel,
    output logic preset_strobe,
    output logic timer0_running,
    output logic running
);
    import sequencer_pkg::*;

    seq_state_t state;
    logic [CODE_W-1:0] event_sel [PAIRS];
    logic [CODE_W-1:0] action_sel [PAIRS];
    logic [EXT_W-1:0] ext_meta;
    logic [EXT_W-1:0] ext_sync;
    logic [TIMER_W-1:0] timer0;
    logic timer0_expired;

    // External inputs are asynchronous and pass two flops first.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta <= '0;
            ext_sync <= '0;
        end else begin
            ext_meta <= ext_in;
            ext_sync <= ext_meta;
        end
    end

    // Programming port writes one pair per strobe; out-of-range slots are dropped.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PAIRS; i++) begin
                event_sel[i] <= EV_FALSE;
                action_sel[i] <= ACT_NONE;
            end
        end else if (prog_we && (int'(prog_idx) < PAIRS)) begin
            event_sel[prog_idx] <= prog_event; // [RULE8]
            action_sel[prog_idx] <= prog_action; // [RULE8]
        end
    end

    function automatic logic event_true(input logic [CODE_W-1:0] code,
                                        input logic on_ref,
                                        input logic t0_exp,
                                        input logic [EXT_W-1:0] ext);
        logic r;
        r = 1'b0;
        if (code == EV_TRUE)
            r = 1'b1; // [RULE11]
        else if (code == EV_ON_REF)
            r = on_ref; // [RULE9]
        else if (code == EV_TIMEOUT0)
            r = t0_exp; // [RULE11]
        else if (code >= EV_EXT_BASE && code < EV_EXT_BASE + 6'(EXT_W))
            r = ext[2'(code - EV_EXT_BASE)]; // [RULE9]
        return r;
    endfunction : event_true

    // The count is clamped to the array size so a bad setting cannot index past it.
    wire logic [IDX_W-1:0] eff_count = (int'(pair_count) > PAIRS) ?
                                       IDX_W'(PAIRS) : pair_count; // [RULE6]
    wire logic slot_ok = int'(current_slot) < PAIRS;
    wire logic [CODE_W-1:0] cur_event = slot_ok ? event_sel[current_slot] : EV_FALSE;
    wire logic [CODE_W-1:0] cur_action = slot_ok ? action_sel[current_slot] : ACT_NONE;
    wire logic cur_true = event_true(cur_event, on_reference, timer0_expired,
                                     ext_sync); // [RULE3]
    // Mode is tested here too, so a tick on the edge where mode drops fires nothing.
    wire logic do_eval = mode_on && (state == ST_RUN) && scan_tick
                         && (eff_count != FIRST_SLOT); // [RULE10] [RULE13]
    wire logic fire = do_eval && cur_true; // [RULE1] [RULE4]
    wire logic last_slot = (current_slot + IDX_ONE) >= eff_count;
    wire logic [IDX_W-1:0] next_slot = last_slot ? FIRST_SLOT
                                     : current_slot + IDX_ONE; // [RULE2] [RULE7]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            current_slot <= FIRST_SLOT;
        end else if (!mode_on) begin
            state <= ST_IDLE; // [RULE10]
            current_slot <= FIRST_SLOT;
        end else if (state == ST_IDLE) begin
            state <= ST_RUN;
            current_slot <= FIRST_SLOT; // [RULE5]
        end else if (fire) begin
            current_slot <= next_slot; // [RULE2] [RULE7]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            action_fire <= 1'b0;
            action_code <= ACT_NONE;
            preset_strobe <= 1'b0;
            preset_sel <= 1'b0;
        end else begin
            action_fire <= fire; // [RULE1]
            preset_strobe <= fire && (cur_action == ACT_PRESET0
                                      || cur_action == ACT_PRESET1); // [RULE12]
            if (fire) begin
                action_code <= cur_action;
            end
            if (fire && cur_action == ACT_PRESET0) begin
                preset_sel <= 1'b0; // [RULE12]
            end else if (fire && cur_action == ACT_PRESET1) begin
                preset_sel <= 1'b1; // [RULE12]
            end
        end
    end

    // Timer zero counts mclk cycles; it keeps running when the sequencer stops.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer0 <= TIMER_ZERO;
            timer0_running <= 1'b0;
            timer0_expired <= 1'b0;
        end else if (fire && cur_action == ACT_TIMER0) begin
            timer0 <= TIMER0_LOAD; // [RULE12]
            timer0_running <= 1'b1;
            timer0_expired <= 1'b0;
        end else if (timer0_running) begin
            if (timer0 <= IDX_ONE) begin
                timer0 <= TIMER_ZERO;
                timer0_running <= 1'b0;
                timer0_expired <= 1'b1;
            end else begin
                timer0 <= timer0 - 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            running <= 1'b0;
        else
            running <= mode_on && (state == ST_RUN);
    end

    property p_no_fire_idle;
        @(posedge mclk) disable iff (!rst_n)
        !mode_on |=> !action_fire;
    endproperty
    a_no_fire_idle: assert property (p_no_fire_idle) // [RULE10]
        else $error("Action fired while mode is off.");

    property p_fire_needs_tick;
        @(posedge mclk) disable iff (!rst_n)
        action_fire |-> $past(scan_tick) && $past(state == ST_RUN);
    endproperty
    a_fire_needs_tick: assert property (p_fire_needs_tick) // [RULE13]
        else $error("Action fired without a scan tick.");

    property p_zero_count;
        @(posedge mclk) disable iff (!rst_n)
        (eff_count == FIRST_SLOT) |=> !action_fire;
    endproperty
    a_zero_count: assert property (p_zero_count) // [RULE13]
        else $error("Action fired with zero pairs.");

    property p_false_holds;
        @(posedge mclk) disable iff (!rst_n)
        (do_eval && !cur_true && mode_on) |=> ($stable(current_slot) && !action_fire);
    endproperty
    a_false_holds: assert property (p_false_holds) // [RULE4]
        else $error("Slot moved on a false event.");

    property p_advance;
        @(posedge mclk) disable iff (!rst_n)
        (fire && mode_on && !last_slot) |=> current_slot == $past(current_slot) + IDX_ONE;
    endproperty
    a_advance: assert property (p_advance) // [RULE2]
        else $error("Slot did not advance after an action.");

    property p_wrap;
        @(posedge mclk) disable iff (!rst_n)
        (fire && mode_on && last_slot) |=> current_slot == FIRST_SLOT;
    endproperty
    a_wrap: assert property (p_wrap) // [RULE7]
        else $error("Slot did not wrap after the last pair.");

    property p_start;
        @(posedge mclk) disable iff (!rst_n)
        $rose(mode_on) |=> (current_slot == FIRST_SLOT && state == ST_RUN);
    endproperty
    a_start: assert property (p_start) // [RULE5]
        else $error("Start did not select the first slot.");

    property p_code_pair;
        @(posedge mclk) disable iff (!rst_n)
        fire |=> action_fire && action_code == $past(cur_action);
    endproperty
    a_code_pair: assert property (p_code_pair) // [RULE1]
        else $error("Action code does not match the slot.");

    property p_timer;
        @(posedge mclk) disable iff (!rst_n)
        (fire && cur_action == ACT_TIMER0) |=> timer0_running && !timer0_expired;
    endproperty
    a_timer: assert property (p_timer) // [RULE12]
        else $error("Timer zero not started.");
endmodule : event_action_sequencer

// ---- sim/drive_side_model.sv ----
// Far-side model: drive status and external inputs feeding the sequencer.
`timescale 1ns/1ps
module drive_side_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic upd,
    input wire logic ref_v,
    input wire logic [3:0] ext_v,
    input wire logic preset_strobe,
    output logic on_reference,
    output logic [3:0] ext_in
);
    int preset_cmds;
    // Levels only change on request, so no tick ever sees them mid-change.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            on_reference <= 1'b0;
            ext_in <= 4'h0;
            preset_cmds <= 0;
        end else begin
            if (upd) begin
                on_reference <= ref_v;
                ext_in <= ext_v;
            end
            if (preset_strobe) begin
                preset_cmds <= preset_cmds + 1;
            end
        end
    end
endmodule : drive_side_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the event/action sequencer with a behavioural model.
`timescale 1ns/1ps
module tb_top;
    import sequencer_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, mode_on = 1'b0, scan_tick = 1'b0, prog_we = 1'b0;
    logic upd = 1'b0, ref_v = 1'b0, on_reference, action_fire, preset_sel, preset_strobe;
    logic timer0_running, running;
    logic [IDX_W-1:0] pair_count = 5'h00, prog_idx = 5'h00, current_slot;
    logic [CODE_W-1:0] prog_event = 6'h00, prog_action = 6'h00, action_code;
    logic [EXT_W-1:0] ext_v = 4'h0, ext_in;
    int num_errors = 0, n_checks = 0, seed = 66518, slot = 0, cnt = 0, i, k, a, n_preset = 0;
    bit prev = 0, t0x = 0, psel = 0, md = 0;
    int evm[20], acm[20];
    int ev_tab[$] = '{0, 1, 4, 32, 33, 34, 35};
    int ac_tab[$] = '{1, 10, 11};
    event_action_sequencer #(.TIMER0_LOAD(16'h0005)) event_action_sequencer_i (.mclk(mclk),
        .rst_n(rst_n), .mode_on(mode_on), .scan_tick(scan_tick), .pair_count(pair_count),
        .prog_we(prog_we), .prog_idx(prog_idx), .prog_event(prog_event),
        .prog_action(prog_action), .on_reference(on_reference), .ext_in(ext_in),
        .current_slot(current_slot), .action_fire(action_fire), .action_code(action_code),
        .preset_sel(preset_sel), .preset_strobe(preset_strobe),
        .timer0_running(timer0_running), .running(running));
    drive_side_model drive_side_model_i (.mclk(mclk), .rst_n(rst_n), .upd(upd), .ref_v(ref_v),
        .ext_v(ext_v), .preset_strobe(preset_strobe), .on_reference(on_reference),
        .ext_in(ext_in));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task final_report;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    function bit ev_true(input int c);
        if (c == 1) return 1;
        if (c == 4) return ref_v;
        if (c == 30) return t0x;
        if (c >= 32 && c <= 35) return ext_v[c-32];
        return 0;
    endfunction : ev_true
    // The tick raised on the previous call is judged at this edge.
    task step(input bit t);
        @(posedge mclk);
        scan_tick <= t;
        #1;
        if (prev && md && cnt != 0 && ev_true(evm[slot])) begin
            a = acm[slot];
            if (a == 10 || a == 11) begin
                psel = (a == 11);
                n_preset++;
            end
            if (a == 29) t0x = 0;
            chk(action_fire, 8'h01, "fire");
            chk(action_code, a, "action");
            chk(preset_sel, psel, "preset");
            chk(preset_strobe, (a == 10 || a == 11), "strobe");
            slot = (slot + 1) % cnt;
        end else begin
            chk(action_fire, 8'h00, "idle fire");
        end
        chk(current_slot, slot, "slot");
        prev = t;
    endtask : step
    task setmode(input bit m, input int c);
        @(posedge mclk);
        mode_on <= m;
        pair_count <= c;
        repeat (3) @(posedge mclk);
        #1;
        md = m;
        slot = 0;
        cnt = (c > 20) ? 20 : c;
        chk(running, m, "running");
        chk(current_slot, 8'h00, "start slot");
    endtask : setmode
    task prog(input int n, input int e, input int ac);
        @(posedge mclk);
        prog_we <= 1'b1;
        prog_idx <= n;
        prog_event <= e;
        prog_action <= ac;
        @(posedge mclk);
        prog_we <= 1'b0;
        evm[n] = e;
        acm[n] = ac;
    endtask : prog
    task status(input bit r, input logic [3:0] e);
        @(posedge mclk);
        ref_v <= r;
        ext_v <= e;
        upd <= 1'b1;
        @(posedge mclk);
        upd <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : status
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        final_report();
    end
    initial begin
        for (i = 0; i < 20; i++) begin
            evm[i] = 0;
            acm[i] = 1;
        end
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk(action_code, ACT_NONE, "reset action");
        prog(0, 1, 10);
        prog(1, 4, 29);
        prog(2, 30, 11);
        prog(3, 0, 1);
        setmode(1, 4);
        step(1);
        step(1);
        step(0);
        status(1, 4'h0);
        step(1);
        step(1);
        chk(timer0_running, 8'h01, "timer run");
        repeat (21) step(0);
        chk(timer0_running, 8'h00, "timer done");
        t0x = 1;
        step(1);
        repeat (3) step(1);
        step(0);
        setmode(0, 0);
        repeat (3) step(1);
        step(0);
        setmode(1, 0);
        repeat (4) step(1);
        step(0);
        setmode(0, 0);
        for (i = 0; i < 20; i++) prog(i, 1, (i % 2) ? 11 : 10);
        setmode(1, 20);
        repeat (23) step(1);
        step(0);
        for (k = 0; k < 6; k++) begin
            setmode(0, 0);
            for (i = 0; i < 20; i++) begin
                prog(i, ev_tab[($random(seed) & 3) + 3 * ($random(seed) & 1)],
                    ac_tab[($random(seed) & 1) + ($random(seed) & 1)]);
            end
            setmode(1, $random(seed) & 31);
            repeat (40) begin
                if (($random(seed) & 7) == 0) begin
                    step(0);
                    status($random(seed) & 1, $random(seed) & 15);
                end else begin
                    step($random(seed) & 1);
                end
            end
            step(0);
        end
        // One more edge lets the far side count a strobe raised by the last tick.
        @(posedge mclk);
        #1;
        chk(drive_side_model_i.preset_cmds, n_preset, "preset count");
        final_report();
    end
endmodule : tb_top
